// ==== tb/dtec_bus_mem_model.sv ====
// bus-side memory model: answers each requested cycle after lat_in + 1 wait cycles
`timescale 1ns/1ps
module dtec_bus_mem_model
  import dtec_pkg::*;
(
  // clock and reset
  input  logic       ref_clk_in,
  input  logic       rst_in,
  // cycle request and answer
  input  logic       cyc_valid_in,
  input  logic [3:0] lat_in,
  output logic       bus_done_out
);
  logic [3:0] cnt_r;

  // one done pulse per cycle; restarts when the next cycle is requested
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !cyc_valid_in || bus_done_out) begin
      cnt_r        <= 4'h0;
      bus_done_out <= 1'b0;
    end else if (cnt_r == lat_in) begin
      bus_done_out <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : dtec_bus_mem_model

// ==== tb/dtec_end_ctrl_checker.sv ====
// concurrent checks on the ports of the transfer end control block
`timescale 1ns/1ps
module dtec_end_ctrl_checker
  import dtec_pkg::*;
(
  // clock, reset, enable
  input logic        ref_clk_in,
  input logic        rst_in,
  input logic        ce_in,
  // register port
  input dtec_rbus_t  rbus_in,
  input logic [31:0] rdata_out,
  // transfer side
  input logic        xfer_req_in,
  input logic        bus_done_in,
  input logic        cyc_valid_out,
  input dtec_cyc_t   cyc_out,
  // status
  input logic        active_out,
  input logic        escape_irq_req_out,
  input logic        irq_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in || !ce_in);

  a_active_tracks: assert property (active_out == cyc_valid_out)
    else $error("active differs from cycle valid");
  a_cycle_held: assert property (cyc_valid_out && !bus_done_in |=> cyc_valid_out && $stable(cyc_out))
    else $error("bus cycle dropped or changed before done");
  a_stop_after_done: assert property ($fell(cyc_valid_out) |-> $past(bus_done_in))
    else $error("cycle ended without done");
  a_start_by_req: assert property ($rose(cyc_valid_out) |-> $past(xfer_req_in))
    else $error("cycle started without request");
  a_esc_cause: assert property ($rose(escape_irq_req_out) |-> $past(bus_done_in || xfer_req_in || rbus_in.wr))
    else $error("escape request rose without cause");
  a_esc_idle: assert property (escape_irq_req_out |-> !cyc_valid_out)
    else $error("cycle running while escape flagged");
  a_esc_resume: assert property (escape_irq_req_out && rbus_in.wr && rbus_in.addr == OFS_MODE &&
                                 rbus_in.wdata[MD_DTE] |=> !escape_irq_req_out)
    else $error("resume did not clear escape flag");
  a_esc_fall_wr: assert property ($fell(escape_irq_req_out) |-> $past(rbus_in.wr))
    else $error("escape flag cleared without write");
  a_irq_rise: assert property ($rose(irq_out) |-> $past(bus_done_in || xfer_req_in || rbus_in.wr))
    else $error("irq rose without cause");
  a_irq_fall_wr: assert property ($fell(irq_out) |-> $past(rbus_in.wr))
    else $error("irq fell without write");
  a_rdata_idle: assert property (!$past(rbus_in.rd) |-> rdata_out == 32'h00000000)
    else $error("read data shown without a read");
endmodule : dtec_end_ctrl_checker

bind dtec_end_ctrl dtec_end_ctrl_checker u_dtec_end_ctrl_checker (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in), .rbus_in(rbus_in), .rdata_out(rdata_out),
  .xfer_req_in(xfer_req_in), .bus_done_in(bus_done_in), .cyc_valid_out(cyc_valid_out), .cyc_out(cyc_out),
  .active_out(active_out), .escape_irq_req_out(escape_irq_req_out), .irq_out(irq_out)
);

// ==== tb/dtec_end_ctrl_tb.sv ====
// self-checking testbench for the transfer end control block
`timescale 1ns/1ps
module dtec_end_ctrl_tb
  import dtec_pkg::*;
;
  logic        ref_clk_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic        ce_in      = 1'b1;
  dtec_rbus_t  rbus       = '0;
  logic        xreq       = 1'b0;
  logic [3:0]  lat        = 4'h0;
  logic [31:0] rdata;
  logic        done, valid, active, esc, irq;
  dtec_cyc_t   cyc;
  int          n_mismatch = 0;
  int          n_checks   = 0;
  int          nr, nw;

  dtec_end_ctrl u_dtec_end_ctrl (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in), .rbus_in(rbus),
    .rdata_out(rdata), .xfer_req_in(xreq), .bus_done_in(done), .cyc_valid_out(valid), .cyc_out(cyc),
    .active_out(active), .escape_irq_req_out(esc), .irq_out(irq));
  dtec_bus_mem_model u_dtec_bus_mem_model (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .cyc_valid_in(valid),
    .lat_in(lat), .bus_done_out(done));

  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // count completed reads and writes
  always @(posedge ref_clk_in) begin
    if (valid && done) begin
      if (cyc.write) begin
        nw++;
        check("write addr", cyc.addr[23:8], 32'h1);
      end else begin
        nr++;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic time_out;
    n_mismatch++;
    $display("CHECK FAILED wait bound expected idle seen busy");
    finish_test();
  endtask : time_out

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    rbus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    rbus <= '0;
    @(posedge ref_clk_in);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    rbus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    rbus <= '0;
    @(posedge ref_clk_in);
    d = rdata;
  endtask : reg_rd

  task automatic idle_wait;
    int i, q;
    q = 0;
    for (i = 0; i < 300 && q < 4; i++) begin
      @(posedge ref_clk_in);
      q = valid ? 0 : q + 1;
    end
    if (q < 4) time_out();
  endtask : idle_wait

  // one request; optional software stop while the first cycle runs
  task automatic xfer(input logic exp, input logic sw, input logic [31:0] md);
    int   i;
    logic seen;
    seen = 1'b0;
    xreq <= 1'b1;
    for (i = 0; i < 20 && !seen; i++) begin
      @(posedge ref_clk_in);
      seen = valid;
    end
    xreq <= 1'b0;
    check("cycle started", seen, exp);
    if (sw) reg_wr(OFS_MODE, md);
    idle_wait();
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] v;
    reg_rd(OFS_MODE, v);
    check("mode reset", v, 32'h0);
    reg_rd(OFS_SIZE, v);
    check("size reset", v, 32'h1);
    reg_wr(8'h1C, 32'hFFFFFFFF);
    reg_rd(8'h1C, v);
    check("unmapped read", v, 32'h0);
    reg_wr(OFS_MODE, 32'h00000080);
    reg_rd(OFS_MODE, v);
    check("active read only", v, 32'h0);
    reg_wr(OFS_IRQ_MASK, 32'h0000000F);
    $display("test registers done");
  endtask : t_regs

  task automatic run_case(input string nm, input logic [7:0] md, input logic [11:0] ac, input logic [7:0] src,
                          input logic [15:0] sz, input logic sw, input int nq, input int erd, input int ewr,
                          input logic [3:0] est);
    int          k;
    logic [31:0] v;
    lat <= sw ? 4'h4 : 4'h0;
    reg_wr(OFS_SIZE, {16'h0, sz});
    reg_wr(OFS_SRC, {24'h0, src});
    reg_wr(OFS_DST, 32'h00000100);
    reg_wr(OFS_ADDR_CTRL, {20'h0, ac});
    reg_wr(OFS_IRQ_STAT, 32'h0000000F);
    reg_wr(OFS_MODE, {24'h0, md} | 32'h3);
    nr = 0;
    nw = 0;
    for (k = 0; k < nq; k++) begin
      xfer(!(est[IS_RPT_END] && k == nq - 1), sw && k == 0, {24'h0, md} | 32'h2);
    end
    check({nm, " reads"}, nr, erd);
    check({nm, " writes"}, nw, ewr);
    reg_rd(OFS_IRQ_STAT, v);
    check({nm, " status"}, v, {28'h0, est});
    reg_rd(OFS_MODE, v);
    check({nm, " mode flags"}, v[2:0], {est[IS_ESCAPE], 2'b10});
    check({nm, " escape irq"}, esc, est[IS_ESCAPE]);
    $display("test %s done", nm);
  endtask : run_case

  task automatic t_resume;
    reg_wr(OFS_MODE, 32'h00000026);
    check("flag kept on write one", esc, 1'b1);
    reg_wr(OFS_MODE, 32'h00000023);
    check("flag after resume", esc, 1'b0);
    xfer(1'b1, 1'b0, 32'h0);
    check("stopped again", esc, 1'b1);
    $display("test resume done");
  endtask : t_resume

  task automatic t_irq;
    check("irq on", irq, 1'b1);
    reg_wr(OFS_IRQ_MASK, 32'h0);
    check("irq masked", irq, 1'b0);
    reg_wr(OFS_IRQ_MASK, 32'h0000000F);
    check("irq unmasked", irq, 1'b1);
    reg_wr(OFS_IRQ_STAT, 32'h00000008);
    check("irq cleared", irq, 1'b0);
    $display("test irq done");
  endtask : t_irq

  // clock enable low freezes the register port; a mid-run reset clears the mode register
  task automatic t_freeze;
    logic [31:0] v;
    ce_in <= 1'b0;
    reg_wr(OFS_MODE, 32'h00000001);
    ce_in <= 1'b1;
    reg_rd(OFS_MODE, v);
    check("mode frozen", v, 32'h32);
    rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    reg_rd(OFS_MODE, v);
    check("mode after reset", v, 32'h0);
    $display("test freeze done");
  endtask : t_freeze

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    t_regs();
    run_case("repeat end", 8'h10, 12'h001, 8'h00, 16'h0002, 1'b0, 3, 2, 0, 4'h3);
    run_case("block end", 8'h20, 12'h001, 8'h00, 16'h0003, 1'b0, 2, 3, 0, 4'h3);
    run_case("cluster end", 8'h30, 12'h001, 8'h00, 16'h0002, 1'b0, 2, 2, 0, 4'h3);
    run_case("dual ovf", 8'h40, 12'h012, 8'h01, 16'h0004, 1'b0, 1, 1, 1, 4'h5);
    run_case("block ovf", 8'h20, 12'h012, 8'h00, 16'h0004, 1'b0, 1, 4, 0, 4'h5);
    t_resume();
    run_case("cluster ovf", 8'h70, 12'h012, 8'h00, 16'h0002, 1'b0, 1, 2, 2, 4'h5);
    reg_wr(OFS_MODE, 32'h00000072);
    check("flag cleared by zero", esc, 1'b0);
    run_case("normal stop", 8'h40, 12'h000, 8'h00, 16'h0004, 1'b1, 1, 1, 1, 4'h8);
    run_case("block stop", 8'h20, 12'h000, 8'h00, 16'h0003, 1'b1, 1, 3, 0, 4'h8);
    run_case("cluster stop", 8'h30, 12'h000, 8'h00, 16'h0003, 1'b1, 1, 3, 0, 4'h8);
    t_irq();
    t_freeze();
    finish_test();
  end
endmodule : dtec_end_ctrl_tb

// ==== verilog/dtec_addr_gen.sv ====
// address counter with extended repeat area wrap and overflow detection
`timescale 1ns/1ps
module dtec_addr_gen
  import dtec_pkg::*;
(
  // clock and reset
  input  logic              ref_clk_in,
  input  logic              rst_in,
  input  logic              ce_in,
  // software load
  input  logic              load_in,
  input  logic [ADDR_W-1:0] load_val_in,
  // area and stepping
  input  logic [AREA_W-1:0] area_in,
  input  logic              adv_in,
  // result
  output logic [ADDR_W-1:0] addr_out,
  output logic              ovf_out
);

  logic [ADDR_W-1:0] addr_r;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      addr_r <= RST_ADDR;
    end else if (ce_in) begin
      if (load_in) begin
        addr_r <= load_val_in;
      end else if (adv_in) begin
        addr_r <= area_next(addr_r, area_in);
      end
    end
  end

  assign addr_out = addr_r;
  // pulse in the cycle whose step leaves the area
  assign ovf_out  = ce_in && adv_in && !load_in && area_edge(addr_r, area_in);

endmodule : dtec_addr_gen

// ==== verilog/dtec_end_ctrl.sv ====
// dma channel sequencer with transfer end control and its register port
//
// Function
// RQ1 - repeat mode with repeat irq enabled: request after repeat size ends raises repeat-end.
// RQ2 - repeat-end stops transfer, clears enable and sets escape flag together.
// RQ3 - software may set enable again after repeat-end stop; transfer then resumes.
// RQ4 - block mode: request after a finished block raises repeat-end.
// RQ5 - cluster mode: request after a finished cluster raises repeat-end.
// RQ6 - enabled area overflow stops transfer, clears enable, sets escape flag together.
// RQ7 - dual address: overflow in read still lets the following write complete.
// RQ8 - block mode: overflow stop waits for the block to finish.
// RQ9 - cluster mode: overflow stop waits for the cluster to finish.
// RQ10 - software enable clear stops after the running or accepted cycle.
// RQ11 - block mode: software enable clear waits for the running block.
// RQ12 - cluster mode: software enable clear waits for the running cluster.
// RQ13 - escape irq request is high while escape flag and its enable are set.
// RQ14 - setting enable to resume clears the escape flag automatically.
// RQ15 - apart from RQ14, escape flag clears only by writing zero after reading it as one.
`timescale 1ns/1ps
module dtec_end_ctrl
  import dtec_pkg::*;
(
  // clock, reset, enable
  input  logic       ref_clk_in,
  input  logic       rst_in,
  input  logic       ce_in,
  // register port
  input  dtec_rbus_t rbus_in,
  output logic [31:0] rdata_out,
  // transfer request and bus cycle
  input  logic       xfer_req_in,
  input  logic       bus_done_in,
  output logic       cyc_valid_out,
  output dtec_cyc_t  cyc_out,
  // status
  output logic       active_out,
  output logic       escape_irq_req_out,
  output logic       irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic               dte_r;
  logic               escape_irq_enable_r;
  logic               escape_irq_flag_r;
  logic               escape_irq_flag_seen_r;
  dtec_mode_t         mode_r;
  logic               dual_r;
  logic [11:0]        actrl_r;
  logic [SIZE_W-1:0]  size_r;
  logic [SIZE_W-1:0]  cnt_r;
  logic [IRQ_W-1:0]   irq_stat_r;
  logic [IRQ_W-1:0]   irq_mask_r;
  logic [31:0]        rdata_r;

  dtec_state_t        state_r;
  dtec_state_t        state_nxt;
  logic               size_done_r;
  logic               ovf_pend_r;
  dtec_cyc_t          cyc_r;

  logic               wr_mode;
  logic               wr_src;
  logic               wr_dst;
  logic               wr_size;
  logic               rd_mode;
  logic [ADDR_W-1:0]  src_addr;
  logic [ADDR_W-1:0]  dst_addr;
  logic               src_ovf;
  logic               dst_ovf;
  logic               src_ovf_hit;
  logic               dst_ovf_hit;
  logic               unit_mode;
  logic               rpt_capable;
  logic               xfer_end;
  logic               unit_last;
  logic               boundary;
  logic               stop_rpt;
  logic               stop_ovf;
  logic               stop_sw;
  logic               stop_flag;
  logic [AREA_W-1:0]  src_area;
  logic [AREA_W-1:0]  dst_area;

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  assign wr_mode  = ce_in && rbus_in.wr && (rbus_in.addr == OFS_MODE);
  assign wr_src   = ce_in && rbus_in.wr && (rbus_in.addr == OFS_SRC);
  assign wr_dst   = ce_in && rbus_in.wr && (rbus_in.addr == OFS_DST);
  assign wr_size  = ce_in && rbus_in.wr && (rbus_in.addr == OFS_SIZE);
  assign rd_mode  = ce_in && rbus_in.rd && (rbus_in.addr == OFS_MODE);

  assign src_area = actrl_r[AC_SAREA_LO +: AREA_W];
  assign dst_area = actrl_r[AC_DAREA_LO +: AREA_W];

  ////////////////////////////////////////////////////////////////////////////
  // address generators
  dtec_addr_gen u_src (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .load_in     (wr_src),
    .load_val_in (rbus_in.wdata[ADDR_W-1:0]),
    .area_in     (src_area),
    .adv_in      (bus_done_in && (state_r == ST_READ)),
    .addr_out    (src_addr),
    .ovf_out     (src_ovf)
  );

  dtec_addr_gen u_dst (
    .ref_clk_in  (ref_clk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .load_in     (wr_dst),
    .load_val_in (rbus_in.wdata[ADDR_W-1:0]),
    .area_in     (dst_area),
    .adv_in      (bus_done_in && (state_r == ST_WRITE)),
    .addr_out    (dst_addr),
    .ovf_out     (dst_ovf)
  );

  ////////////////////////////////////////////////////////////////////////////
  // end conditions
  assign src_ovf_hit = src_ovf && actrl_r[AC_SOURCE_AREA_IRQ_ENABLE];                                  // RQ6
  assign dst_ovf_hit = dst_ovf && actrl_r[AC_DEST_AREA_IRQ_ENABLE];                                  // RQ6
  assign unit_mode   = (mode_r == XM_BLOCK) || (mode_r == XM_CLUSTER);
  assign rpt_capable = (mode_r != XM_NORMAL);
  assign unit_last   = (cnt_r == 16'h0001);
  // a transfer ends after its write, or after its only cycle in single address mode
  assign xfer_end    = ce_in && bus_done_in &&
                       ((state_r == ST_WRITE) || ((state_r == ST_READ) && !dual_r));  // RQ7
  // in block and cluster mode only the last transfer of a unit is a stop point
  assign boundary    = xfer_end && (!unit_mode || unit_last);                         // RQ8 RQ9 RQ11 RQ12
  assign stop_rpt    = ce_in && (state_r == ST_WAIT) && dte_r && xfer_req_in &&
                       size_done_r && rpt_capable && actrl_r[AC_REPEAT_END_IRQ_ENABLE];               // RQ1 RQ4 RQ5
  assign stop_ovf    = boundary && (ovf_pend_r || src_ovf_hit || dst_ovf_hit);        // RQ6
  assign stop_sw     = boundary && !stop_ovf && !dte_r;                               // RQ10
  assign stop_flag   = stop_rpt || stop_ovf;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (dte_r) begin
          state_nxt = ST_WAIT;                                                        // RQ3
        end
      end
      ST_WAIT: begin
        if (!dte_r || stop_rpt) begin
          state_nxt = ST_IDLE;                                                        // RQ2
        end else if (xfer_req_in) begin
          state_nxt = ST_READ;
        end
      end
      ST_READ: begin
        if (bus_done_in && dual_r) begin
          state_nxt = ST_WRITE;                                                       // RQ7
        end else if (bus_done_in) begin
          state_nxt = (stop_ovf || stop_sw) ? ST_IDLE : (boundary ? ST_WAIT : ST_READ);
        end
      end
      ST_WRITE: begin
        if (bus_done_in) begin
          state_nxt = (stop_ovf || stop_sw) ? ST_IDLE : (boundary ? ST_WAIT : ST_READ);
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
    end else if (ce_in) begin
      state_r <= state_nxt;
    end
  end

  // bus cycle descriptor, loaded as each cycle begins
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cyc_r <= '0;
    end else if (ce_in) begin
      if ((state_nxt == ST_READ) && ((state_r != ST_READ) || bus_done_in)) begin
        cyc_r.addr  <= (state_r == ST_READ) ? area_next(src_addr, src_area) : src_addr;
        cyc_r.write <= 1'b0;
      end else if ((state_nxt == ST_WRITE) && (state_r != ST_WRITE)) begin
        cyc_r.addr  <= dst_addr;
        cyc_r.write <= 1'b1;
      end
    end
  end

  // transfer counter for repeat, block and cluster size
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cnt_r <= RST_SIZE;
    end else if (ce_in) begin
      if (wr_size) begin
        cnt_r <= rbus_in.wdata[SIZE_W-1:0];
      end else if (xfer_end && rpt_capable) begin
        cnt_r <= unit_last ? size_r : cnt_r - 16'h0001;
      end
    end
  end

  // a finished repeat, block or cluster waits for the next request
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      size_done_r <= 1'b0;
    end else if (ce_in) begin
      if (xfer_end && rpt_capable && unit_last) begin
        size_done_r <= 1'b1;
      end else if (stop_rpt || ((state_r == ST_WAIT) && xfer_req_in && dte_r)) begin
        size_done_r <= 1'b0;
      end
    end
  end

  // overflow held until the unit boundary
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ovf_pend_r <= 1'b0;
    end else if (ce_in) begin
      if (boundary || (state_r == ST_IDLE)) begin
        ovf_pend_r <= 1'b0;
      end else if (src_ovf_hit || dst_ovf_hit) begin
        ovf_pend_r <= 1'b1;                                                           // RQ8 RQ9
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer enable and escape flag
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      dte_r <= 1'b0;
    end else if (ce_in) begin
      if (stop_flag) begin
        dte_r <= 1'b0;                                                                // RQ2 RQ6
      end else if (wr_mode) begin
        dte_r <= rbus_in.wdata[MD_DTE];                                               // RQ3 RQ10
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      escape_irq_flag_r <= 1'b0;
    end else if (ce_in) begin
      if (stop_flag) begin
        escape_irq_flag_r <= 1'b1;                                                               // RQ2 RQ6
      end else if (wr_mode && rbus_in.wdata[MD_DTE]) begin
        escape_irq_flag_r <= 1'b0;                                                               // RQ14
      end else if (wr_mode && !rbus_in.wdata[MD_ESCAPE_IRQ_FLAG] && escape_irq_flag_seen_r) begin
        escape_irq_flag_r <= 1'b0;                                                               // RQ15
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      escape_irq_flag_seen_r <= 1'b0;
    end else if (ce_in) begin
      if (!escape_irq_flag_r || wr_mode) begin
        escape_irq_flag_seen_r <= 1'b0;
      end else if (rd_mode) begin
        escape_irq_flag_seen_r <= 1'b1;                                                          // RQ15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      escape_irq_enable_r  <= 1'b0;
      mode_r  <= XM_NORMAL;
      dual_r  <= 1'b0;
      actrl_r <= RST_ACTRL;
      size_r  <= RST_SIZE;
    end else if (ce_in) begin
      if (wr_mode) begin
        escape_irq_enable_r <= rbus_in.wdata[MD_ESCAPE_IRQ_ENABLE];
      end
      // mode and addressing change only while no transfer is running
      if (wr_mode && !active_out) begin
        mode_r <= dtec_mode_t'(rbus_in.wdata[MD_MODE_LO +: 2]);
        dual_r <= rbus_in.wdata[MD_DUAL];
      end
      if (ce_in && rbus_in.wr && (rbus_in.addr == OFS_ADDR_CTRL)) begin
        actrl_r <= rbus_in.wdata[11:0];
      end
      if (wr_size) begin
        size_r <= rbus_in.wdata[SIZE_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      irq_stat_r <= RST_IRQ;
      irq_mask_r <= RST_IRQ;
    end else if (ce_in) begin
      // a new event wins over a write-one clear in the same cycle
      irq_stat_r <= (irq_stat_r &
                     ~((rbus_in.wr && (rbus_in.addr == OFS_IRQ_STAT)) ? rbus_in.wdata[IRQ_W-1:0] : RST_IRQ)) |
                    {stop_sw, stop_ovf, stop_rpt, stop_flag};
      if (rbus_in.wr && (rbus_in.addr == OFS_IRQ_MASK)) begin
        irq_mask_r <= rbus_in.wdata[IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the strobe
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_r <= 32'h00000000;
    end else if (ce_in) begin
      rdata_r <= 32'h00000000;
      if (rbus_in.rd) begin
        if (rbus_in.addr == OFS_MODE) begin
          rdata_r[MD_DTE]           <= dte_r;
          rdata_r[MD_ESCAPE_IRQ_ENABLE]          <= escape_irq_enable_r;
          rdata_r[MD_ESCAPE_IRQ_FLAG]          <= escape_irq_flag_r;
          rdata_r[MD_MODE_LO +: 2]  <= mode_r;
          rdata_r[MD_DUAL]          <= dual_r;
          rdata_r[MD_ACT]           <= active_out;
        end else if (rbus_in.addr == OFS_ADDR_CTRL) begin
          rdata_r[11:0]             <= actrl_r;
        end else if (rbus_in.addr == OFS_SRC) begin
          rdata_r[ADDR_W-1:0]       <= src_addr;
        end else if (rbus_in.addr == OFS_DST) begin
          rdata_r[ADDR_W-1:0]       <= dst_addr;
        end else if (rbus_in.addr == OFS_SIZE) begin
          rdata_r[SIZE_W-1:0]       <= size_r;
        end else if (rbus_in.addr == OFS_IRQ_STAT) begin
          rdata_r[IRQ_W-1:0]        <= irq_stat_r;
        end else if (rbus_in.addr == OFS_IRQ_MASK) begin
          rdata_r[IRQ_W-1:0]        <= irq_mask_r;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata_out          = rdata_r;
  assign cyc_valid_out      = (state_r == ST_READ) || (state_r == ST_WRITE);
  assign cyc_out            = cyc_r;
  assign active_out         = cyc_valid_out;
  assign escape_irq_req_out = escape_irq_flag_r && escape_irq_enable_r;                                       // RQ13
  assign irq_out            = |(irq_stat_r & irq_mask_r);

endmodule : dtec_end_ctrl

// ==== verilog/dtec_pkg.sv ====
// package of constants, types and helpers for the dma transfer end control block
package dtec_pkg;

  localparam int          ADDR_W         = 24;
  localparam int          AREA_W         = 4;
  localparam int          SIZE_W         = 16;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [7:0]  OFS_MODE       = 8'h00;
  localparam logic [7:0]  OFS_ADDR_CTRL  = 8'h04;
  localparam logic [7:0]  OFS_SRC        = 8'h08;
  localparam logic [7:0]  OFS_DST        = 8'h0C;
  localparam logic [7:0]  OFS_SIZE       = 8'h10;
  localparam logic [7:0]  OFS_IRQ_STAT   = 8'h14;
  localparam logic [7:0]  OFS_IRQ_MASK   = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // ext_mode_control_reg fields
  localparam int          MD_DTE         = 0;
  localparam int          MD_ESCAPE_IRQ_ENABLE        = 1;
  localparam int          MD_ESCAPE_IRQ_FLAG        = 2;
  localparam int          MD_MODE_LO     = 4;
  localparam int          MD_DUAL        = 6;
  localparam int          MD_ACT         = 7;

  // ext_address_control_reg fields
  localparam int          AC_REPEAT_END_IRQ_ENABLE       = 0;
  localparam int          AC_SOURCE_AREA_IRQ_ENABLE       = 1;
  localparam int          AC_DEST_AREA_IRQ_ENABLE       = 2;
  localparam int          AC_SAREA_LO    = 4;
  localparam int          AC_DAREA_LO    = 8;

  // interrupt status / mask bits
  localparam int          IRQ_W          = 4;
  localparam int          IS_ESCAPE      = 0;
  localparam int          IS_RPT_END     = 1;
  localparam int          IS_OVF         = 2;
  localparam int          IS_SW_STOP     = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [1:0]        RST_MODE   = 2'h0;
  localparam logic [11:0]       RST_ACTRL  = 12'h000;
  localparam logic [ADDR_W-1:0] RST_ADDR   = 24'h000000;
  localparam logic [SIZE_W-1:0] RST_SIZE   = 16'h0001;
  localparam logic [IRQ_W-1:0]  RST_IRQ    = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    XM_NORMAL  = 2'b00,
    XM_REPEAT  = 2'b01,
    XM_BLOCK   = 2'b10,
    XM_CLUSTER = 2'b11
  } dtec_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_READ  = 2'b10,
    ST_WRITE = 2'b11
  } dtec_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dtec_rbus_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
  } dtec_cyc_t;

  ////////////////////////////////////////////////////////////////////////////
  // extended repeat area helpers: area of 2**n bytes, n = 0 means no area
  function automatic logic [ADDR_W-1:0] area_mask(input logic [AREA_W-1:0] n);
    area_mask = (24'h000001 << n) - 24'h000001;
  endfunction : area_mask

  function automatic logic area_edge(input logic [ADDR_W-1:0] a, input logic [AREA_W-1:0] n);
    area_edge = (n != 4'h0) && ((a & area_mask(n)) == area_mask(n));
  endfunction : area_edge

  function automatic logic [ADDR_W-1:0] area_next(input logic [ADDR_W-1:0] a, input logic [AREA_W-1:0] n);
    if (area_edge(a, n)) begin
      area_next = a & ~area_mask(n);
    end else begin
      area_next = a + 24'h000001;
    end
  endfunction : area_next

endpackage : dtec_pkg
